// ===== shared/port2_pkg.sv
`default_nettype none
package port2_pkg;
   // Pin count and register widths
   localparam int          PIN_COUNT       = 7;
   localparam int          DATA_W          = 32;
   localparam int          ADDR_W          = 12;
   // Printed offsets are indices, byte address is four times the index
   localparam logic [7:0]  DIR_INDEX       = 8'h0A;
   localparam logic [7:0]  OUT_INDEX       = 8'h0B;
   localparam logic [7:0]  PIN_INDEX       = 8'h0C;
   localparam logic [11:0] DIR_ADDR        = {2'b00, DIR_INDEX, 2'b00};
   localparam logic [11:0] OUT_ADDR        = {2'b00, OUT_INDEX, 2'b00};
   localparam logic [11:0] PIN_ADDR        = {2'b00, PIN_INDEX, 2'b00};
   // Values after reset
   localparam logic [6:0]  DIR_RESET       = 7'h00;
   localparam logic [6:0]  OUT_RESET       = 7'h00;
   // Field positions
   localparam int          DIR_LSB         = 0;
   localparam int          DIR_RSVD_BIT    = 7;
   // Slave answers with one wait-free access phase
   localparam int          APB_WAIT_CYCLES = 0;
endpackage
`default_nettype wire

// ===== verilog/port2_pin_cell.sv
`default_nettype none
module port2_pin_cell (
   // Control
   input  wire logic dirOut,
   input  wire logic latchBit,
   // Pad control
   output logic      padOut,
   output logic      padOe,
   output logic      pullupEn
);
   // Output drives latch; input uses latch as pullup enable
   always_comb begin
      padOe    = dirOut;
      padOut   = dirOut & latchBit;
      pullupEn = ~dirOut & latchBit;
   end
endmodule
`default_nettype wire

// ===== verilog/port2_direction_pullup_ctrl.sv
// Implementation choice: the APB register port.
`default_nettype none
// Summary of operation
// - Every reset clears the direction register so all pins start as inputs.
// - Each of the seven pins has its own direction bit in bits 6 to 0.
// - A pin with direction 1 drives its output-latch bit with driver on.
// - A pin with direction 0 has its driver off and works as an input.
// - An input pin with latch bit 1 has its weak pullup switched on.
// - An input pin with latch bit 0 has pullup off and floats three-state.
// - Direction bit 7 is reserved: reads 0 and ignores writes.
module port2_direction_pullup_ctrl #(
   parameter int PINS = port2_pkg::PIN_COUNT
) (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           arst_n,
   // APB slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [port2_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [port2_pkg::DATA_W-1:0]   pwdata,
   input  wire logic [3:0]                     pstrb,
   output logic      [port2_pkg::DATA_W-1:0]   prdata,
   output logic                                pready,
   output logic                                pslverr,
   // Port pins
   input  wire logic [PINS-1:0]                pinIn,
   output logic      [PINS-1:0]                pinOut,
   output logic      [PINS-1:0]                pinOe,
   output logic      [PINS-1:0]                pullupEn
);

   logic [PINS-1:0] dir_q;
   logic [PINS-1:0] latch_q;
   logic [PINS-1:0] cellOut;
   logic [PINS-1:0] cellOe;
   logic [PINS-1:0] cellPull;
   logic            setup;
   logic            wrDir;
   logic            wrOut;
   logic            mapped;

   // Access in setup cycle; answer ready in the access phase that follows
   assign setup  = psel & ~penable;
   assign mapped = (paddr == port2_pkg::DIR_ADDR) |
                   (paddr == port2_pkg::OUT_ADDR) |
                   (paddr == port2_pkg::PIN_ADDR);
   // Writes take effect at the completing edge, low byte lane only
   assign wrDir  = psel & penable & pready & pwrite & pstrb[0] &
                   (paddr == port2_pkg::DIR_ADDR);
   assign wrOut  = psel & penable & pready & pwrite & pstrb[0] &
                   (paddr == port2_pkg::OUT_ADDR);

   // Direction register, cleared by any reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dir_q <= port2_pkg::DIR_RESET;
      end else if (wrDir) begin
         // Bit 7 of the write is dropped
         dir_q <= pwdata[PINS-1:0];
      end
   end

   // Output latch: data for outputs, pullup select for inputs
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         latch_q <= port2_pkg::OUT_RESET;
      end else if (wrOut) begin
         latch_q <= pwdata[PINS-1:0];
      end
   end

   // One cell per pin keeps the pins independent
   for (genvar i = 0; i < PINS; i++) begin : g_pin
      port2_pin_cell u_cell (
         .dirOut   (dir_q[i]),
         .latchBit (latch_q[i]),
         .padOut   (cellOut[i]),
         .padOe    (cellOe[i]),
         .pullupEn (cellPull[i])
      );
   end

   // Pad outputs registered; one cycle after a register write
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pinOut   <= '0;
         pinOe    <= '0;
         pullupEn <= '0;
      end else begin
         pinOut   <= cellOut;
         pinOe    <= cellOe;
         pullupEn <= cellPull;
      end
   end

   // APB answer: one access cycle, read data captured at setup
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else if (setup) begin
         pready  <= 1'b1;
         pslverr <= ~mapped;
         prdata  <= '0;
         if (!pwrite) begin
            case (paddr)
               port2_pkg::DIR_ADDR: prdata[PINS-1:0] <= dir_q;
               port2_pkg::OUT_ADDR: prdata[PINS-1:0] <= latch_q;
               port2_pkg::PIN_ADDR: prdata[PINS-1:0] <= pinIn;
               default:             prdata <= '0;
            endcase
         end
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ===== tb/port2_checker.sv
`default_nettype none
module port2_checker (
   // Bus side
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   // Pads
   input wire logic [6:0]  pinOut,
   input wire logic [6:0]  pinOe,
   input wire logic [6:0]  pullupEn
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Completed write with low byte lane on, then which word it hit
   wire logic acc = psel && penable && pready && pwrite && pstrb[0];
   wire logic wrDir = acc && paddr == port2_pkg::DIR_ADDR;
   wire logic wrOut = acc && paddr == port2_pkg::OUT_ADDR;
   chk_reset_idle: assert property ($rose(arst_n) |-> pinOe == 7'h00)
      else $error("pins driven after reset");
   chk_dir_drive: assert property (
      wrDir |=> ##1 pinOe == 7'($past(pwdata, 2))) else $error("dir");
   chk_latch_use: assert property (
      wrOut |=> ##1 (pinOut | pullupEn) == 7'($past(pwdata, 2)))
      else $error("latch");
   chk_out_gated: assert property ((pinOut & ~pinOe) == 7'h00)
      else $error("input pin driven");
   chk_pull_input: assert property ((pullupEn & pinOe) == 7'h00)
      else $error("pullup on output");
   chk_rsvd_zero: assert property (
      pready && !pwrite && paddr == port2_pkg::DIR_ADDR |-> prdata[31:7] == 0)
      else $error("reserved bit set");
   chk_pin_hold: assert property ($changed(pinOe) |-> $past(acc, 2))
      else $error("pins moved without write");
   chk_ready_next: assert property (psel && !penable |=> pready)
      else $error("no answer");
endmodule
bind port2_direction_pullup_ctrl port2_checker port2_checker_i (.clk,
   .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
   .pready, .pinOut, .pinOe, .pullupEn);
`default_nettype wire

// ===== tb/port2_pins_model.sv
`default_nettype none
module port2_pins_model (
   // Pad control
   input  wire logic       clk,
   input  wire logic [6:0] pinOut,
   input  wire logic [6:0] pinOe,
   input  wire logic [6:0] pullupEn,
   // Level back at pads
   output logic      [6:0] pinIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic flip = 1'b0;
   // Floating pad settles nowhere, so show a toggling level
   always_ff @(posedge clk) flip <= ~flip;
   assign pinIn = (pinOe & pinOut) | (~pinOe & (pullupEn | {7{flip}}));
endmodule
`default_nettype wire

// ===== tb/port2_direction_pullup_ctrl_tb.sv
`default_nettype none
module port2_direction_pullup_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, d, l;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr;
   logic [6:0] pinIn, pinOut, pinOe, pullupEn;
   int failures = 0, checks = 0, dir, lat;
   always #12.5 clk = ~clk;
   port2_direction_pullup_ctrl port2_direction_pullup_ctrl_i (.clk, .arst_n,
      .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .pinIn, .pinOut, .pinOe, .pullupEn);
   port2_pins_model port2_pins_model_i (.clk, .pinOut, .pinOe, .pullupEn,
      .pinIn);
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      checks++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic apb(logic w, logic [11:0] a, logic [31:0] wd);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk) penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask
   task automatic end_of_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h12BBCBA9));
      repeat (5) @(posedge clk);
      arst_n <= 1;
      @(posedge clk);
      for (int i = 0; i < 40; i++) begin
         // Second pass starts with a mid-run reset
         if (i % 20 == 0) begin
            arst_n <= 0;
            @(posedge clk) arst_n <= 1;
            apb(0, port2_pkg::DIR_ADDR, 0);
            chk("dirReset", rd, 0);
         end
         d = $urandom;
         l = $urandom;
         apb(1, port2_pkg::DIR_ADDR, d);
         dir = d & 'h7F;
         apb(1, port2_pkg::OUT_ADDR, l);
         lat = l & 'h7F;
         apb(0, port2_pkg::DIR_ADDR, 0);
         chk("dir", rd, dir);
         chk("pinOe", pinOe, dir);
         chk("pinOut", pinOut, dir & lat);
         chk("pullupEn", pullupEn, ~dir & lat);
         // Driven and pulled pins read back as the latch; floating masked
         apb(0, port2_pkg::PIN_ADDR, 0);
         chk("pinLevel", rd & (dir | lat), lat);
      end
      // A write with the low byte lane off must leave direction alone
      pstrb <= 4'h0;
      apb(1, port2_pkg::DIR_ADDR, ~dir);
      pstrb <= 4'hF;
      apb(0, port2_pkg::DIR_ADDR, 0);
      chk("dirStrb", rd, dir);
      apb(0, 12'h100, 0);
      chk("pslverr", err, 1);
      end_of_test;
   end
   initial begin
      #100000;
      failures++;
      end_of_test;
   end
endmodule
`default_nettype wire
